// ==== include/t1rx_pkg.sv ====
// constants, encodings and carriers for the t1 receive event monitor
package t1rx_pkg;

  // ==========================================================
  // line formats
  typedef enum logic [1:0] {
    T1RX_FMT_SF  = 2'h0,  // superframe
    T1RX_FMT_ESF = 2'h1,  // extended superframe
    T1RX_FMT_DM  = 2'h2,  // digital data service frame
    T1RX_FMT_SLC = 2'h3   // subscriber loop carrier frame
  } t1rx_fmt_t;

  // one received line bit with its frame position from the aligner
  typedef struct packed {
    logic       bit_en;     // one-cycle strobe: a line bit is present
    logic       data;       // received bit value
    logic       f_slot;     // this bit sits in the framing position
    logic       fbit_exp;   // expected framing bit value
    logic [6:0] frame_idx;  // basic frame number in multiframe, from 1
  } t1rx_line_t;

  // ==========================================================
  // register indexes (byte address is four times the index)
  localparam logic [7:0] T1RX_IDX_STATUS  = 8'h4F;
  localparam logic [7:0] T1RX_IDX_EN0     = 8'h50;
  localparam logic [7:0] T1RX_IDX_EN1     = 8'h51;
  localparam logic [7:0] T1RX_IDX_FLAGS0  = 8'h52;
  localparam logic [7:0] T1RX_IDX_FLAGS1  = 8'h53;
  localparam logic [7:0] T1RX_IDX_OVH0    = 8'h56;
  localparam logic [7:0] T1RX_IDX_OVH1    = 8'h57;
  localparam logic [7:0] T1RX_IDX_OVH2    = 8'h58;
  localparam logic [7:0] T1RX_IDX_OVH_EN  = 8'h5C;
  localparam logic [7:0] T1RX_IDX_OVH_FLG = 8'h5D;

  // ==========================================================
  // field positions
  localparam int T1RX_B_OOF     = 0;  // flags0: sync status change
  localparam int T1RX_B_MIMIC   = 4;  // flags0: mimic seen
  localparam int T1RX_B_ALIGN   = 0;  // flags1: alignment moved
  localparam int T1RX_B_FERR    = 1;  // flags1: framing bit error
  localparam int T1RX_B_CRC     = 2;  // flags1: crc block error
  localparam int T1RX_B_SEVERE  = 3;  // flags1: severe framing error
  localparam int T1RX_B_FSTART  = 4;  // flags1: frame start
  localparam int T1RX_B_DEBOUNCE = 4; // overhead enable reg: debounce

  // ==========================================================
  // reset values
  localparam logic [7:0] T1RX_RST_BYTE = 8'h00;
  localparam logic       T1RX_RST_OOS  = 1'b1;  // out of sync at reset

  // ==========================================================
  // frame positions and counts
  localparam logic [6:0] T1RX_FRAME_FIRST = 7'h01;
  localparam logic [6:0] T1RX_WIN2_FIRST  = 7'h07;  // second 6-frame win
  localparam logic [6:0] T1RX_CRC_LAST    = 7'h16;  // frame 22
  localparam logic [6:0] T1RX_SLC_SYNC_HI = 7'h16;  // frame 2n, n <= 11
  localparam logic [6:0] T1RX_SLC_SYNC_36 = 7'h48;  // frame 72 (n = 36)
  localparam logic [6:0] T1RX_SLC_OVH_LO  = 7'h18;  // frame 24 (n = 12)
  localparam logic [6:0] T1RX_SLC_OVH_HI  = 7'h3E;  // frame 62 (n = 31)
  localparam logic [1:0] T1RX_SEVERE_CNT  = 2'h2;   // errors per window
  localparam logic [5:0] T1RX_CRC_POLY    = 6'h03;  // x^6 + x + 1

  // overhead word: conc [10:0], maint [13:11], alarm [15:14],
  // switch [19:16]; change flag index 0 conc, 1 maint, 2 sw, 3 alarm
  localparam int T1RX_OVH_W = 20;
  localparam logic [19:0] T1RX_MASK_CONC  = 20'h007FF;
  localparam logic [19:0] T1RX_MASK_MAINT = 20'h03800;
  localparam logic [19:0] T1RX_MASK_SW    = 20'hF0000;
  localparam logic [19:0] T1RX_MASK_ALARM = 20'h0C000;

endpackage

// ==== src/t1rx_monitor.sv ====
// t1 receive framing event flags and slc-96 overhead extraction
`timescale 1ns/1ps

// Functional notes
// - mimic pattern sets sticky flag in sf/esf
// - any out-of-sync change sets sticky flag
// - frame start flag, frozen while out of sync
// - two ft errors per six frames: severe
// - two alignment errors per esf multiframe: severe
// - crc-6 mismatch against next multiframe's crc bits
// - every checked framing bit mismatch sets error flag (esf checks frames 4, 8, ...)
// - slc-96 checks odd ft and chosen fs bits
// - new lock position differing sets move flag
// - flags clear on write one only
// - eleven concentrator bits, first bit lsb
// - three maintenance bits, first bit lsb
// - four switch bits, first bit lsb
// - two alarm bits, first bit lsb
// - debounce needs two equal superframes to update
// - fields held while slc sync lost
// - debounce control bit resets to zero
// - change flag with enable drives interrupt
// - alarm field change sets alarm flag
// - switch field change sets switch flag
// - maintenance and concentrator changes set flags
// - status reads one when out of sync
module t1rx_monitor (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  // apb slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [11:0]       paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  // line side from the aligner
  input  wire t1rx_pkg::t1rx_line_t line_i,
  input  wire t1rx_pkg::t1rx_fmt_t  fmt_i,
  input  wire logic              out_of_sync_i,
  input  wire logic              mimic_i,
  input  wire logic              lock_i,
  input  wire logic [7:0]        lock_pos_i,
  // interrupt
  output logic                   irq_n_o
);
  import t1rx_pkg::*;

  // ==========================================================
  // functions

  // framing bit positions that are compared in each format
  function automatic logic fbit_checked(t1rx_fmt_t f, logic [6:0] idx);
    logic slc_fs;
    slc_fs = (!idx[0] && idx <= T1RX_SLC_SYNC_HI) ||
             (idx == T1RX_SLC_SYNC_36);
    unique case (f)
      T1RX_FMT_ESF: fbit_checked = (idx[1:0] == 2'h0);
      T1RX_FMT_SLC: fbit_checked = idx[0] || slc_fs;
      default:      fbit_checked = 1'b1;
    endcase
  endfunction

  // one serial step of crc-6
  function automatic logic [5:0] crc_step(logic [5:0] c, logic b);
    crc_step = {c[4:0], 1'b0} ^ ((c[5] ^ b) ? T1RX_CRC_POLY : 6'h00);
  endfunction

  // ==========================================================
  // declarations
  logic [7:0]  flags0;         // mimic and sync-change flags
  logic [7:0]  flags1;         // framing event flags
  logic [3:0]  ovh_flags;      // overhead change flags
  logic [7:0]  en0;            // enables for flags0
  logic [4:0]  en1;            // enables for flags1
  logic [4:0]  ovh_en;         // debounce and change enables
  logic        oos;            // registered out-of-sync status
  logic [7:0]  lock_pos;       // last locked framing position
  logic        lock_seen;      // a position has been locked before
  logic [1:0]  sev_cnt;        // errors in current severe window
  logic [5:0]  crc_acc;        // crc of current esf multiframe
  logic [5:0]  crc_prev;       // crc of previous esf multiframe
  logic [5:0]  crc_rx;         // received crc bits being gathered
  logic        crc_valid;      // crc_prev covers a whole multiframe
  logic        crc_run;        // a multiframe start has been seen
  logic [19:0] ovh_rx;         // overhead bits of this superframe
  logic [19:0] ovh_prev;       // overhead bits of last superframe
  logic [19:0] ovh;            // extracted overhead fields
  logic [19:0] next_ovh;       // candidate overhead fields
  logic [3:0]  ovh_chg;        // per field change this superframe
  logic [19:0] masks [4];      // field masks by change flag index

  // decoded line events
  logic        fslot;          // framing bit strobe
  logic        mism;           // checked framing bit mismatches
  logic        sev_bit;        // bit counts toward severe window
  logic        win_start;      // first framing bit of a window
  logic        sev_ev;         // severe error event
  logic        crc_ev;         // crc error event
  logic        fstart_ev;      // frame start event
  logic        align_ev;       // alignment moved event
  logic        slc_end;        // last framing bit of slc superframe
  logic [7:0]  ev0;            // set vector for flags0
  logic [7:0]  ev1;            // set vector for flags1
  logic [7:0]  rx_crc_now;     // helper to size compare
  logic [7:0]  wr_byte;        // low byte of write data

  // apb decode
  logic        setup;          // setup phase of a transfer
  logic        access;         // access phase accepted this edge
  logic [7:0]  idx;            // register index
  logic        mapped;         // index hits a register
  logic [7:0]  rd_byte;        // read mux
  logic        wr;             // write takes effect this edge

  assign masks[0] = T1RX_MASK_CONC;
  assign masks[1] = T1RX_MASK_MAINT;
  assign masks[2] = T1RX_MASK_SW;
  assign masks[3] = T1RX_MASK_ALARM;

  // ==========================================================
  // apb slave: no wait state, read data captured in setup
  assign setup   = psel_i && !penable_i;
  assign access  = psel_i && penable_i && pready_o;
  assign idx     = paddr_i[9:2];
  assign wr      = access && pwrite_i && !pslverr_o;
  assign wr_byte = pwdata_i[7:0];

  // address decode
  always_comb begin
    mapped = (paddr_i[1:0] == 2'h0) && (paddr_i[11:10] == 2'h0);
    rd_byte = 8'h00;
    unique case (idx)
      T1RX_IDX_STATUS:  rd_byte = {7'h00, oos};
      T1RX_IDX_EN0:     rd_byte = en0;
      T1RX_IDX_EN1:     rd_byte = {3'h0, en1};
      T1RX_IDX_FLAGS0:  rd_byte = flags0;
      T1RX_IDX_FLAGS1:  rd_byte = flags1;
      T1RX_IDX_OVH0:    rd_byte = ovh[7:0];
      T1RX_IDX_OVH1:    rd_byte = {2'h0, ovh[13:8]};
      T1RX_IDX_OVH2:    rd_byte = {2'h0, ovh[19:14]};
      T1RX_IDX_OVH_EN:  rd_byte = {3'h0, ovh_en};
      T1RX_IDX_OVH_FLG: rd_byte = {4'h0, ovh_flags};
      default:          mapped = 1'b0;                      // unmapped
    endcase
  end

  // answer handshake
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= setup;
      pslverr_o <= setup && !mapped;
      if (setup) begin
        prdata_o <= (pwrite_i || !mapped) ? 32'h0000_0000
                                          : {24'h000000, rd_byte};
      end
    end
  end

  // writable control registers
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      en0    <= T1RX_RST_BYTE;
      en1    <= 5'h00;
      ovh_en <= 5'h00;
    end else if (wr) begin
      if (idx == T1RX_IDX_EN0)    en0    <= wr_byte & 8'h11;
      if (idx == T1RX_IDX_EN1)    en1    <= wr_byte[4:0];
      if (idx == T1RX_IDX_OVH_EN) ovh_en <= wr_byte[4:0];
    end
  end

  // ==========================================================
  // framing bit checks
  assign fslot   = line_i.bit_en && line_i.f_slot;
  assign mism    = fslot && fbit_checked(fmt_i, line_i.frame_idx) &&
                   (line_i.data != line_i.fbit_exp);
  assign sev_bit = mism && (fmt_i != T1RX_FMT_SLC) &&
                   ((fmt_i == T1RX_FMT_ESF) || line_i.frame_idx[0]);
  assign win_start = fslot &&
    ((line_i.frame_idx == T1RX_FRAME_FIRST) ||
     (fmt_i != T1RX_FMT_ESF && line_i.frame_idx == T1RX_WIN2_FIRST));
  assign sev_ev  = sev_bit && !win_start &&
                   (sev_cnt == T1RX_SEVERE_CNT - 2'h1);

  // fixed-window severe error count
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      sev_cnt <= 2'h0;
    end else if (win_start) begin
      sev_cnt <= sev_bit ? 2'h1 : 2'h0;
    end else if (sev_bit && sev_cnt != 2'h3) begin
      sev_cnt <= sev_cnt + 2'h1;
    end
  end

  // ==========================================================
  // crc-6 over each esf multiframe, framing bits counted as one
  assign rx_crc_now = {2'h0, crc_rx[4:0], line_i.data};
  assign crc_ev = fslot && fmt_i == T1RX_FMT_ESF && crc_valid &&
                  line_i.frame_idx == T1RX_CRC_LAST &&
                  rx_crc_now[5:0] != crc_prev;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      crc_acc   <= 6'h00;
      crc_prev  <= 6'h00;
      crc_rx    <= 6'h00;
      crc_valid <= 1'b0;
      crc_run   <= 1'b0;
    end else if (fmt_i != T1RX_FMT_ESF || oos) begin
      crc_acc   <= 6'h00;                // restart after a loss
      crc_valid <= 1'b0;
      crc_run   <= 1'b0;
    end else if (line_i.bit_en) begin
      if (fslot && line_i.frame_idx == T1RX_FRAME_FIRST) begin
        crc_prev  <= crc_acc;
        // the first start only opens a run; a partial crc is no check
        crc_valid <= crc_run;
        crc_run   <= 1'b1;
        crc_acc   <= crc_step(6'h00, 1'b1);
      end else begin
        crc_acc <= crc_step(crc_acc, line_i.f_slot | line_i.data);
      end
      // crc bits ride the framing slot of frames 2, 6, 10 ...
      if (fslot && line_i.frame_idx[1:0] == 2'h2) begin
        crc_rx <= {crc_rx[4:0], line_i.data};
      end
    end
  end

  // ==========================================================
  // sync status, frame start and lock position
  assign fstart_ev = fslot && !oos &&
                     line_i.frame_idx == T1RX_FRAME_FIRST;
  assign align_ev  = lock_i && lock_seen && lock_pos_i != lock_pos;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      oos       <= T1RX_RST_OOS;
      lock_pos  <= 8'h00;
      lock_seen <= 1'b0;
    end else begin
      oos <= out_of_sync_i;
      if (lock_i) begin
        lock_pos  <= lock_pos_i;
        lock_seen <= 1'b1;
      end
    end
  end

  // ==========================================================
  // sticky event flags: set wins over a write-one clear
  always_comb begin
    ev0 = 8'h00;
    ev1 = 8'h00;
    ev0[T1RX_B_OOF]    = (out_of_sync_i != oos);
    ev0[T1RX_B_MIMIC]  = mimic_i && (fmt_i == T1RX_FMT_SF ||
                         fmt_i == T1RX_FMT_ESF);
    ev1[T1RX_B_ALIGN]  = align_ev;
    ev1[T1RX_B_FERR]   = mism;
    ev1[T1RX_B_CRC]    = crc_ev;
    ev1[T1RX_B_SEVERE] = sev_ev;
    ev1[T1RX_B_FSTART] = fstart_ev;
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      flags0 <= T1RX_RST_BYTE;
      flags1 <= T1RX_RST_BYTE;
    end else begin
      flags0 <= ((wr && idx == T1RX_IDX_FLAGS0) ? flags0 & ~wr_byte
                                                : flags0) | ev0;
      flags1 <= ((wr && idx == T1RX_IDX_FLAGS1) ? flags1 & ~wr_byte
                                                : flags1) | ev1;
    end
  end

  // ==========================================================
  // slc-96 overhead gathering from fs bits of frames 24..62
  assign slc_end = fslot && fmt_i == T1RX_FMT_SLC &&
                   line_i.frame_idx == T1RX_SLC_SYNC_36;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ovh_rx <= 20'h00000;
    end else if (fslot && fmt_i == T1RX_FMT_SLC &&
                 !line_i.frame_idx[0] &&
                 line_i.frame_idx >= T1RX_SLC_OVH_LO &&
                 line_i.frame_idx <= T1RX_SLC_OVH_HI) begin
      // first received bit of each field lands in its lsb
      ovh_rx[5'(line_i.frame_idx[6:1] - 6'd12)] <= line_i.data;
    end
  end

  // per field debounce select and change detect
  always_comb begin
    next_ovh = ovh;
    ovh_chg  = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (!ovh_en[T1RX_B_DEBOUNCE] ||
          ((ovh_rx ^ ovh_prev) & masks[i]) == 20'h00000) begin
        next_ovh = (next_ovh & ~masks[i]) | (ovh_rx & masks[i]);
      end
      ovh_chg[i] = ((next_ovh ^ ovh) & masks[i]) != 20'h00000;
    end
  end

  // field update once per superframe, frozen while out of sync
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ovh      <= 20'h00000;
      ovh_prev <= 20'h00000;
    end else if (slc_end && !oos) begin
      ovh      <= next_ovh;
      ovh_prev <= ovh_rx;
    end
  end

  // overhead change flags, write one to clear
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ovh_flags <= 4'h0;
    end else begin
      ovh_flags <= ((wr && idx == T1RX_IDX_OVH_FLG)
                    ? ovh_flags & ~wr_byte[3:0]
                    : ovh_flags) |
                   ((slc_end && !oos) ? ovh_chg : 4'h0);
    end
  end

  // ==========================================================
  // interrupt output, active low
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      irq_n_o <= 1'b1;
    end else begin
      irq_n_o <= !(|(flags0 & en0) || |(flags1[4:0] & en1) ||
                   |(ovh_flags & ovh_en[3:0]));
    end
  end

  // ==========================================================
  // checks
  sequence s_setup;
    psel_i && !penable_i;
  endsequence

  a_sync_change: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (out_of_sync_i != oos) |=> flags0[T1RX_B_OOF])
    else $error("sync change flag not set");
  a_fbit_error: assert property (@(posedge clk_i) disable iff (!resetn_i)
    mism |=> flags1[T1RX_B_FERR])
    else $error("framing error flag not set");
  a_start_frozen: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (oos && !flags1[T1RX_B_FSTART]) |=> !flags1[T1RX_B_FSTART])
    else $error("frame start flag moved while out of sync");
  a_ready_follows: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_setup |=> pready_o ##1 !pready_o)
    else $error("apb answer timing wrong");
  a_flag_sticky: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (flags1[T1RX_B_CRC] && !(wr && idx == T1RX_IDX_FLAGS1))
    |=> flags1[T1RX_B_CRC])
    else $error("crc flag dropped without write");
  a_fields_held: assert property (@(posedge clk_i) disable iff (!resetn_i)
    oos |=> $stable(ovh))
    else $error("overhead changed while out of sync");
  a_alarm_change: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (ovh[15:14] != $past(ovh[15:14])) |-> ovh_flags[3])
    else $error("alarm change flag not set");
  a_conc_change: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (ovh[10:0] != $past(ovh[10:0])) |-> ovh_flags[0])
    else $error("concentrator change flag not set");
  a_irq_drive: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (ovh_flags[1] && ovh_en[1]) |=> !irq_n_o)
    else $error("interrupt not asserted");
  a_severe_two: assert property (@(posedge clk_i) disable iff (!resetn_i)
    sev_ev |-> sev_cnt == 2'h1 ##1 flags1[T1RX_B_SEVERE])
    else $error("severe error flag timing wrong");

endmodule

// ==== test/t1rx_line_model.sv ====
// far-end line source: framed bits as the aligner hands them over
`timescale 1ns/1ps
module t1rx_line_model (
  // clock
  input  wire logic                 clk_i,
  // framed bit stream toward the monitor
  output t1rx_pkg::t1rx_line_t      line_o
);
  import t1rx_pkg::*;

  // ==========================================================
  // idle state: no strobe, all lines quiet
  initial line_o = '0;

  // ==========================================================
  // one framing bit for one cycle, then every line is inverted so
  // that a stale value can never pass for a fresh one
  task automatic send(input logic [6:0] idx, input logic val,
                      input logic exp);
    @(posedge clk_i);
    line_o <= '{1'b1, val, 1'b1, exp, idx};
    @(posedge clk_i);
    line_o <= '{1'b0, ~val, 1'b0, ~exp, ~idx};
  endtask
endmodule

// ==== test/t1rx_monitor_bench.sv ====
// self-checking bench for the t1 receive event monitor
`timescale 1ns/1ps
module t1rx_monitor_bench;
  import t1rx_pkg::*;

  // ==========================================================
  // design inputs and outputs
  logic        clk_i = 1'b0, resetn_i = 1'b0;
  logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o;
  logic        pready_o, pslverr_o, irq_n_o;
  t1rx_line_t  line_w;
  t1rx_fmt_t   fmt_i = T1RX_FMT_SF;
  logic        out_of_sync_i = 1'b1, mimic_i = 1'b0, lock_i = 1'b0;
  logic [7:0]  lock_pos_i = 8'h00;
  int          error_cnt = 0, n_compared = 0;

  t1rx_line_model i_far (.clk_i(clk_i), .line_o(line_w));
  t1rx_monitor i_dut (.clk_i(clk_i), .resetn_i(resetn_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .line_i(line_w),
    .fmt_i(fmt_i), .out_of_sync_i(out_of_sync_i), .mimic_i(mimic_i),
    .lock_i(lock_i), .lock_pos_i(lock_pos_i), .irq_n_o(irq_n_o));

  // 40 mhz clock
  always #12.5 clk_i = ~clk_i;

  // ==========================================================
  // shared tasks
  task automatic end_of_test();
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one apb transfer; the answer is awaited under a bounded count
  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [7:0] wd, output logic [7:0] rd,
                     output logic err);
    int n;
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= {2'h0, idx, 2'h0};
    pwdata_i <= {24'h0, wd};
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    rd = prdata_o[7:0];
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (pready_o !== 1'b1) begin
      error_cnt++;
      end_of_test();
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] r;
    logic       e;
    apb(1'b1, idx, d, r, e);
  endtask

  task automatic rchk(input string nm, input logic [7:0] idx,
                      input logic [7:0] exp);
    logic [7:0] r;
    logic       e;
    apb(1'b0, idx, 8'h00, r, e);
    chk(nm, exp, r);
  endtask

  task automatic irq_chk(input logic exp);
    repeat (3) @(posedge clk_i);
    chk("irq_n_o", {7'h0, exp}, {7'h0, irq_n_o});
  endtask

  // one slc superframe: fs bits n = 12..31 in sent order, then frame 72
  task automatic sframe(input logic [19:0] v);
    for (int n = 12; n <= 31; n++) i_far.send(7'(2 * n), v[n - 12], 1'b0);
    i_far.send(T1RX_SLC_SYNC_36, 1'b0, 1'b0);
  endtask

  // three overhead words expected from a sent overhead vector
  task automatic ovh_chk(input logic [19:0] v);
    rchk("ovh0", T1RX_IDX_OVH0, v[7:0]);
    rchk("ovh1", T1RX_IDX_OVH1, {2'h0, v[13:11], v[10:8]});
    rchk("ovh2", T1RX_IDX_OVH2, {2'h0, v[19:16], v[15:14]});
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    logic [7:0] r;
    logic       e;
    rchk("status", T1RX_IDX_STATUS, 8'h01);
    ovh_chk(20'h00000);
    rchk("ovh_en", T1RX_IDX_OVH_EN, 8'h00);
    apb(1'b0, 8'h10, 8'h00, r, e);
    chk("unmapped err", 8'h01, {7'h0, e});
  endtask

  task automatic t_fbit();
    out_of_sync_i <= 1'b0;
    rchk("flags0 sync", T1RX_IDX_FLAGS0, 8'h01);
    rchk("status", T1RX_IDX_STATUS, 8'h00);
    wr(T1RX_IDX_FLAGS0, 8'h01);
    i_far.send(T1RX_FRAME_FIRST, 1'b1, 1'b0);
    rchk("flags1 ferr", T1RX_IDX_FLAGS1, 8'h12);
    wr(T1RX_IDX_EN1, 8'h02);
    irq_chk(1'b0);
    wr(T1RX_IDX_FLAGS1, 8'h00);
    rchk("flags1 w0", T1RX_IDX_FLAGS1, 8'h12);
    wr(T1RX_IDX_FLAGS1, 8'h12);
    rchk("flags1 w1", T1RX_IDX_FLAGS1, 8'h00);
    irq_chk(1'b1);
    wr(T1RX_IDX_EN1, 8'h00);
  endtask

  task automatic t_severe();
    i_far.send(7'h01, 1'b1, 1'b0);
    i_far.send(7'h03, 1'b0, 1'b1);
    rchk("severe in", T1RX_IDX_FLAGS1, 8'h1A);
    wr(T1RX_IDX_FLAGS1, 8'h1F);
    i_far.send(T1RX_FRAME_FIRST, 1'b0, 1'b0);
    i_far.send(7'h05, 1'b1, 1'b0);
    i_far.send(T1RX_WIN2_FIRST, 1'b1, 1'b0);
    rchk("severe split", T1RX_IDX_FLAGS1, 8'h12);
    wr(T1RX_IDX_FLAGS1, 8'h1F);
    out_of_sync_i <= 1'b1;
    i_far.send(T1RX_FRAME_FIRST, 1'b0, 1'b0);
    rchk("fstart oos", T1RX_IDX_FLAGS1, 8'h00);
    rchk("flags0 rise", T1RX_IDX_FLAGS0, 8'h01);
    wr(T1RX_IDX_FLAGS0, 8'h11);
  endtask

  task automatic t_misc();
    @(posedge clk_i);
    mimic_i <= 1'b1;
    lock_i <= 1'b1;
    lock_pos_i <= 8'h03;
    @(posedge clk_i);
    mimic_i <= 1'b0;
    lock_i <= 1'b0;
    @(posedge clk_i);
    lock_i <= 1'b1;
    lock_pos_i <= 8'h05;
    @(posedge clk_i);
    lock_i <= 1'b0;
    rchk("mimic", T1RX_IDX_FLAGS0, 8'h10);
    rchk("align move", T1RX_IDX_FLAGS1, 8'h01);
    wr(T1RX_IDX_FLAGS0, 8'h11);
    wr(T1RX_IDX_FLAGS1, 8'h1F);
  endtask

  // two alignment errors 4 frames apart share one esf window
  task automatic t_esf();
    fmt_i <= T1RX_FMT_ESF;
    out_of_sync_i <= 1'b0;
    i_far.send(7'h04, 1'b1, 1'b0);
    i_far.send(7'h08, 1'b1, 1'b0);
    rchk("esf severe", T1RX_IDX_FLAGS1, 8'h0A);
    wr(T1RX_IDX_FLAGS1, 8'h1F);
  endtask

  task automatic t_slc();
    fmt_i <= T1RX_FMT_SLC;
    out_of_sync_i <= 1'b0;
    sframe(20'h9ADA3);
    ovh_chk(20'h9ADA3);
    rchk("ovh flags", T1RX_IDX_OVH_FLG, 8'h0F);
    wr(T1RX_IDX_OVH_FLG, 8'h0F);
    sframe(20'h96DA3);
    ovh_chk(20'h96DA3);
    rchk("alarm only", T1RX_IDX_OVH_FLG, 8'h08);
    wr(T1RX_IDX_OVH_EN, 8'h07);
    irq_chk(1'b1);
    wr(T1RX_IDX_OVH_EN, 8'h18);
    irq_chk(1'b0);
    sframe(20'h9ADA3);
    ovh_chk(20'h96DA3);
    sframe(20'h9ADA3);
    ovh_chk(20'h9ADA3);
    wr(T1RX_IDX_OVH_FLG, 8'h0F);
    irq_chk(1'b1);
    out_of_sync_i <= 1'b1;
    sframe(20'h00000);
    ovh_chk(20'h9ADA3);
  endtask

  // ==========================================================
  // run: reset for four cycles, then every scenario in turn
  initial begin
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_reset();
    t_fbit();
    t_severe();
    t_misc();
    t_esf();
    t_slc();
    end_of_test();
  end
endmodule
